// >>> tb/external_and_pin_change_irq_bench.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Drives the register bus and the pins, and checks the flags and requests.
module external_and_pin_change_irq_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic sleep_active = 1'b0;
  logic auto_ack = 1'b0;
  logic gie_cmd = 1'b0;
  logic [7:0] pin_cmd = 8'hFF;
  logic [12:0] watch_cmd = 13'h0000;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic gie, grp0_req, grp1_req, awready, wready, bvalid, arready, rvalid;
  logic [7:0] ext_irq_pin, ext_irq_ack, ext_irq_request;
  logic [12:0] change_watch_input;
  logic [1:0] change_group_ack, bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ro [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h03, 8'h00, 8'hFF,
    8'h1F};
  int err_count = 0;
  int n_compared = 0;
  int i;

  // The clock runs at 10 MHz.
  always #50 aclk = ~aclk;

  // Design and its far-side partner.
  ext_pin_irq_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .gie(gie),
    .sleep_active(sleep_active), .ext_irq_pin(ext_irq_pin),
    .change_watch_input(change_watch_input), .ext_irq_ack(ext_irq_ack),
    .change_group_ack(change_group_ack), .ext_irq_request(ext_irq_request),
    .change_group0_request(grp0_req), .change_group1_request(grp1_req),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  pin_cpu_model partner (.aclk(aclk), .aresetn(aresetn), .auto_ack(auto_ack),
    .gie_cmd(gie_cmd), .pin_cmd(pin_cmd), .watch_cmd(watch_cmd),
    .ext_irq_request(ext_irq_request), .change_group0_request(grp0_req),
    .change_group1_request(grp1_req), .gie(gie), .ext_irq_pin(ext_irq_pin),
    .change_watch_input(change_watch_input), .ext_irq_ack(ext_irq_ack),
    .change_group_ack(change_group_ack));

  ////////////////////////////////////////////////////////////////////////////
  // Compares one result and counts it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("Mismatches %0d, compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // An expired wait counts as a mismatch and closes the run.
  task tmo(input bit late);
    if (late) begin
      err_count++;
      $display("Error at %0t: wait expired, got %h expected %h", $time, 0, 1);
      summarize();
    end
  endtask

  // Bus write; address and data go out together, bready is held up.
  task wr(input logic [7:0] a, input logic [7:0] d,
          input logic [1:0] er = irq_pkg::RESP_OKAY);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    tmo(k == 50);
    chk(32'(bresp), 32'(er));
  endtask

  // Bus read; rready is held up until the data arrive.
  task rd(input logic [7:0] a, input logic [7:0] ed,
          input logic [1:0] er = irq_pkg::RESP_OKAY);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    tmo(k == 50);
    chk(rdata, {24'h000000, ed});
    chk(32'(rresp), 32'(er));
  endtask

  // Sets the pin levels and lets the sampling settle.
  task pins(input logic [7:0] p, input logic [12:0] w);
    @(posedge aclk);
    pin_cmd <= p;
    watch_cmd <= w;
    repeat (5) @(posedge aclk);
  endtask

  // Sets the global enable and lets the requests settle.
  task set_gie(input logic g);
    @(posedge aclk);
    gie_cmd <= g;
    repeat (4) @(posedge aclk);
  endtask

  // Waits a bounded time for one pin request to reach a level.
  task wait_ext(input int n, input logic v);
    int k;
    for (k = 0; k < 20 && ext_irq_request[n] !== v; k++) @(posedge aclk);
    tmo(k == 20);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of scenarios.
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then read-back after writing all ones to every register.
    for (i = 0; i < 8; i++) begin
      rd(8'(i * 4), irq_pkg::REG_RESET);
      wr(8'(i * 4), 8'hFF);
      rd(8'(i * 4), ro[i]);
      wr(8'(i * 4), 8'h00);
    end
    rd(8'h20, 8'h00, irq_pkg::RESP_SLVERR);
    wr(8'h20, 8'hFF, irq_pkg::RESP_SLVERR);
    // Edge modes on pin four, any change then falling then rising, each flag cleared by W1C.
    for (i = 1; i < 4; i++) begin
      wr(irq_pkg::MASK_OFS, 8'h00);
      wr(irq_pkg::SENSE_HI_OFS, 8'(i));
      pins(8'hEF, 13'h0000);
      wr(irq_pkg::FLAGS_OFS, 8'hFF);
      pins(8'hFF, 13'h0000);
      rd(irq_pkg::FLAGS_OFS, (i != 2) ? 8'h10 : 8'h00);
      wr(irq_pkg::FLAGS_OFS, 8'hFF);
      pins(8'hEF, 13'h0000);
      rd(irq_pkg::FLAGS_OFS, (i != 3) ? 8'h10 : 8'h00);
    end
    // Low level on pin four requests while enabled; its flag stays clear.
    wr(irq_pkg::SENSE_HI_OFS, 8'h00);
    wr(irq_pkg::MASK_OFS, 8'h10);
    set_gie(1'b1);
    chk(32'(ext_irq_request[4]), 32'h1);
    rd(irq_pkg::FLAGS_OFS, 8'h00);
    set_gie(1'b0);
    chk(32'(ext_irq_request[4]), 32'h0);
    set_gie(1'b1);
    wr(irq_pkg::MASK_OFS, 8'h00);
    repeat (4) @(posedge aclk);
    chk(32'(ext_irq_request[4]), 32'h0);
    // Rising edge on pin five is vectored and the ack clears its flag.
    pins(8'hDF, 13'h0000);
    wr(irq_pkg::SENSE_HI_OFS, 8'h0C);
    wr(irq_pkg::FLAGS_OFS, 8'hFF);
    wr(irq_pkg::MASK_OFS, 8'h20);
    auto_ack <= 1'b1;
    pin_cmd <= 8'hFF;
    wait_ext(5, 1'b1);
    wait_ext(5, 1'b0);
    rd(irq_pkg::FLAGS_OFS, 8'h00);
    auto_ack <= 1'b0;
    // Sleep gates the masked lower pin, which reads as a change.
    wr(irq_pkg::MASK_OFS, 8'h00);
    wr(irq_pkg::SENSE_LO_OFS, 8'h01);
    wr(irq_pkg::FLAGS_OFS, 8'hFF);
    sleep_active <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(irq_pkg::FLAGS_OFS, 8'h01);
    sleep_active <= 1'b0;
    // Change groups: excluded input, flag, enable and W1C.
    wr(irq_pkg::PC_MASK_LO_OFS, 8'h01);
    pins(8'hFF, 13'h0002);
    rd(irq_pkg::PC_FLAGS_OFS, 8'h00);
    pins(8'hFF, 13'h0003);
    rd(irq_pkg::PC_FLAGS_OFS, 8'h01);
    wr(irq_pkg::PC_CTRL_OFS, 8'h01);
    repeat (4) @(posedge aclk);
    chk(32'(grp0_req), 32'h1);
    wr(irq_pkg::PC_FLAGS_OFS, 8'h01);
    repeat (4) @(posedge aclk);
    chk(32'(grp0_req), 32'h0);
    wr(irq_pkg::PC_MASK_HI_OFS, 8'h10);
    pins(8'hFF, 13'h1003);
    rd(irq_pkg::PC_FLAGS_OFS, 8'h02);
    chk(32'(grp1_req), 32'h0);
    wr(irq_pkg::PC_CTRL_OFS, 8'h03);
    repeat (4) @(posedge aclk);
    chk(32'(grp1_req), 32'h1);
    // The handler entry clears the group flag and drops the request.
    auto_ack <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'(grp1_req), 32'h0);
    rd(irq_pkg::PC_FLAGS_OFS, 8'h00);
    // A low clock enable freezes sampling; the change lands once it returns.
    auto_ack <= 1'b0;
    ce <= 1'b0;
    pins(8'hFF, 13'h0003);
    chk(32'(grp1_req), 32'h0);
    ce <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(32'(grp1_req), 32'h1);
    summarize();
  end
endmodule // external_and_pin_change_irq_bench

// >>> tb/pin_cpu_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Stands in for the board pins and the CPU vector dispatch.
module pin_cpu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic auto_ack,
  input wire logic gie_cmd,
  input wire logic [7:0] pin_cmd,
  input wire logic [12:0] watch_cmd,
  input wire logic [7:0] ext_irq_request,
  input wire logic change_group0_request,
  input wire logic change_group1_request,
  output logic gie,
  output logic [7:0] ext_irq_pin,
  output logic [12:0] change_watch_input,
  output logic [7:0] ext_irq_ack,
  output logic [1:0] change_group_ack
);
  logic [7:0] ext_hold_ff;
  logic [1:0] grp_hold_ff;

  // Levels move only at an edge, so every pulse lasts a whole period.
  always_ff @(posedge aclk) begin
    ext_irq_pin <= pin_cmd;
    change_watch_input <= watch_cmd;
    gie <= gie_cmd;
  end

  // One vector pulse per request, then the request's lag is waited out.
  always_ff @(posedge aclk) begin
    if (!aresetn || !auto_ack) begin
      ext_irq_ack <= 8'h00;
      change_group_ack <= 2'h0;
    end else begin
      ext_irq_ack <= ext_irq_request & ~ext_irq_ack & ~ext_hold_ff;
      change_group_ack <= {change_group1_request, change_group0_request}
        & ~change_group_ack & ~grp_hold_ff;
    end
    ext_hold_ff <= ext_irq_ack;
    grp_hold_ff <= change_group_ack;
  end
endmodule // pin_cpu_model

// >>> verilog/ext_pin_irq_ctrl.sv
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module ext_pin_irq_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic gie,
  input wire logic sleep_active,
  input wire logic [irq_pkg::EXT_PINS-1:0] ext_irq_pin,
  input wire logic [irq_pkg::WATCH_PINS-1:0] change_watch_input,
  input wire logic [irq_pkg::EXT_PINS-1:0] ext_irq_ack,
  input wire logic [1:0] change_group_ack,
  output logic [irq_pkg::EXT_PINS-1:0] ext_irq_request,
  output logic change_group0_request,
  output logic change_group1_request,
  input wire logic [irq_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [irq_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  typedef enum logic [1:0] {WR_ACCEPT = 2'b01, WR_RESP = 2'b10} wr_state_e;
  typedef enum logic [1:0] {RD_ACCEPT = 2'b01, RD_DATA = 2'b10} rd_state_e;

  typedef struct packed {
    logic [7:0] sense_hi;
    logic [7:0] sense_lo;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [1:0] pc_en;
    logic [1:0] pc_flag;
    logic [irq_pkg::GRP0_W-1:0] pc_msk_lo;
    logic [irq_pkg::GRP1_W-1:0] pc_msk_hi;
    logic [7:0] pin_s;
    logic [7:0] pin_p;
    logic [irq_pkg::WATCH_PINS-1:0] watch_s;
    logic [irq_pkg::WATCH_PINS-1:0] watch_p;
    logic [7:0] ext_req;
    logic [1:0] grp_req;
    wr_state_e wr_st;
    rd_state_e rd_st;
    logic awready;
    logic wready;
    logic have_aw;
    logic have_w;
    logic [irq_pkg::ADDR_W-1:0] waddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic [15:0] sense_all;
  logic [7:0] eff_pin;
  logic [7:0] edge_hit;
  logic [7:0] lvl_v;
  logic [7:0] req_v;
  logic [irq_pkg::WATCH_PINS-1:0] chg;
  logic [1:0] grp_set;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;
  logic [irq_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic wr_take;
  logic [7:0] ext_clr;
  logic [1:0] pc_clr;

  ////////////////////////////////////////////////////////////////////////////
  // True when an address names one of the eight registers.
  function automatic logic is_mapped(input logic [irq_pkg::ADDR_W-1:0] a);
    is_mapped = (a == irq_pkg::SENSE_HI_OFS) || (a == irq_pkg::SENSE_LO_OFS)
      || (a == irq_pkg::MASK_OFS) || (a == irq_pkg::FLAGS_OFS)
      || (a == irq_pkg::PC_CTRL_OFS) || (a == irq_pkg::PC_FLAGS_OFS)
      || (a == irq_pkg::PC_MASK_LO_OFS) || (a == irq_pkg::PC_MASK_HI_OFS);
  endfunction

  // Read value of one register; narrow fields zero-extend.
  function automatic logic [31:0] read_reg(
    input state_s s,
    input logic [irq_pkg::ADDR_W-1:0] a
  );
    if (a == irq_pkg::SENSE_HI_OFS) begin
      read_reg = 32'(s.sense_hi);
    end else if (a == irq_pkg::SENSE_LO_OFS) begin
      read_reg = 32'(s.sense_lo);
    end else if (a == irq_pkg::MASK_OFS) begin
      read_reg = 32'(s.mask);
    end else if (a == irq_pkg::FLAGS_OFS) begin
      read_reg = 32'(s.flags);
    end else if (a == irq_pkg::PC_CTRL_OFS) begin
      read_reg = 32'(s.pc_en);
    end else if (a == irq_pkg::PC_FLAGS_OFS) begin
      read_reg = 32'(s.pc_flag);
    end else if (a == irq_pkg::PC_MASK_LO_OFS) begin
      read_reg = 32'(s.pc_msk_lo);
    end else if (a == irq_pkg::PC_MASK_HI_OFS) begin
      read_reg = 32'(s.pc_msk_hi);
    end else begin
      read_reg = 32'h0000_0000;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Masked lower pins read low while their buffers are off in sleep.
  assign eff_pin = ext_irq_pin & ~{{(irq_pkg::EXT_PINS-
    irq_pkg::LOWER_PINS){1'b0}}, {irq_pkg::LOWER_PINS{sleep_active}} &
    ~st_ff.mask[irq_pkg::LOWER_PINS-1:0]};
  assign sense_all = {st_ff.sense_hi, st_ff.sense_lo};

  // One detector per external pin, fed by successive clocked samples.
  generate
    for (genvar i = 0; i < irq_pkg::EXT_PINS; i++) begin : g_pin
      ext_sense_detect u_det (
        .sense(sense_all[2*i +: 2]),
        .now_lvl(st_ff.pin_s[i]),
        .prev_lvl(st_ff.pin_p[i]),
        .hit(edge_hit[i])
      );
      assign lvl_v[i] = sense_all[2*i +: 2] == irq_pkg::SENSE_LOW;
      assign req_v[i] = lvl_v[i] ? ~st_ff.pin_s[i] : st_ff.flags[i];
    end
  endgenerate

  // A watched input changes when its two samples differ under its mask.
  assign chg = (st_ff.watch_s ^ st_ff.watch_p) &
    {st_ff.pc_msk_hi, st_ff.pc_msk_lo};
  assign grp_set[irq_pkg::GRP0_BIT] = |chg[irq_pkg::GRP0_W-1:0];
  assign grp_set[irq_pkg::GRP1_BIT] =
    |chg[irq_pkg::WATCH_PINS-1:irq_pkg::GRP0_W];

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes and the write that both halves complete.
  assign aw_fire = awvalid & st_ff.awready;
  assign w_fire = wvalid & st_ff.wready;
  assign ar_fire = arvalid & st_ff.arready;
  assign wr_go = (st_ff.wr_st == WR_ACCEPT) & (st_ff.have_aw | aw_fire) &
    (st_ff.have_w | w_fire);
  assign wr_addr = st_ff.have_aw ? st_ff.waddr : awaddr;
  assign wr_byte = st_ff.have_w ? st_ff.wbyte : wdata[7:0];
  assign wr_lane0 = st_ff.have_w ? st_ff.wlane0 : wstrb[0];
  assign wr_take = wr_go & wr_lane0;

  // Clears from the handler entry and from writing ones.
  assign ext_clr = ext_irq_ack |
    ((wr_take && wr_addr == irq_pkg::FLAGS_OFS) ? wr_byte : 8'h00);
  assign pc_clr = change_group_ack |
    ((wr_take && wr_addr == irq_pkg::PC_FLAGS_OFS) ? wr_byte[1:0] : 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block.
  always_comb begin
    nxt_st = st_ff;
    // Pins are sampled whatever their direction.
    nxt_st.pin_s = eff_pin;
    nxt_st.pin_p = st_ff.pin_s;
    nxt_st.watch_s = change_watch_input;
    nxt_st.watch_p = st_ff.watch_s;
    // Register writes; reserved bits are not stored.
    if (wr_take) begin
      if (wr_addr == irq_pkg::SENSE_HI_OFS) begin
        nxt_st.sense_hi = wr_byte;
      end else if (wr_addr == irq_pkg::SENSE_LO_OFS) begin
        nxt_st.sense_lo = wr_byte;
      end else if (wr_addr == irq_pkg::MASK_OFS) begin
        nxt_st.mask = wr_byte;
      end else if (wr_addr == irq_pkg::PC_CTRL_OFS) begin
        nxt_st.pc_en = wr_byte[1:0];
      end else if (wr_addr == irq_pkg::PC_MASK_LO_OFS) begin
        nxt_st.pc_msk_lo = wr_byte;
      end else if (wr_addr == irq_pkg::PC_MASK_HI_OFS) begin
        nxt_st.pc_msk_hi = wr_byte[irq_pkg::GRP1_W-1:0];
      end
    end
    // Flags: a new event wins over a clear in the same cycle.
    nxt_st.flags = ((st_ff.flags & ~ext_clr) | edge_hit) & ~lvl_v;
    nxt_st.pc_flag = (st_ff.pc_flag & ~pc_clr) | grp_set;
    // Requests to the CPU are gated by the global enable.
    nxt_st.ext_req = gie ? (req_v & st_ff.mask) : 8'h00;
    nxt_st.grp_req = gie ? (st_ff.pc_flag & st_ff.pc_en) : 2'h0;
    // Write channel.
    case (st_ff.wr_st)
      WR_ACCEPT: begin
        if (aw_fire) begin
          nxt_st.have_aw = 1'b1;
          nxt_st.awready = 1'b0;
          nxt_st.waddr = awaddr;
        end
        if (w_fire) begin
          nxt_st.have_w = 1'b1;
          nxt_st.wready = 1'b0;
          nxt_st.wbyte = wdata[7:0];
          nxt_st.wlane0 = wstrb[0];
        end
        if (wr_go) begin
          nxt_st.have_aw = 1'b0;
          nxt_st.have_w = 1'b0;
          nxt_st.awready = 1'b0;
          nxt_st.wready = 1'b0;
          nxt_st.bvalid = 1'b1;
          nxt_st.bresp = is_mapped(wr_addr) ? irq_pkg::RESP_OKAY :
            irq_pkg::RESP_SLVERR;
          nxt_st.wr_st = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          nxt_st.bvalid = 1'b0;
          nxt_st.awready = 1'b1;
          nxt_st.wready = 1'b1;
          nxt_st.wr_st = WR_ACCEPT;
        end
      end
      default: nxt_st.wr_st = WR_ACCEPT;
    endcase
    // Read channel.
    case (st_ff.rd_st)
      RD_ACCEPT: begin
        if (ar_fire) begin
          nxt_st.arready = 1'b0;
          nxt_st.rvalid = 1'b1;
          nxt_st.rdata = read_reg(st_ff, araddr);
          nxt_st.rresp = is_mapped(araddr) ? irq_pkg::RESP_OKAY :
            irq_pkg::RESP_SLVERR;
          nxt_st.rd_st = RD_DATA;
        end
      end
      RD_DATA: begin
        if (rready) begin
          nxt_st.rvalid = 1'b0;
          nxt_st.arready = 1'b1;
          nxt_st.rd_st = RD_ACCEPT;
        end
      end
      default: nxt_st.rd_st = RD_ACCEPT;
    endcase
    // Synchronous reset; bus readies come up high.
    if (!aresetn) begin
      nxt_st = '0;
      nxt_st.sense_hi = irq_pkg::REG_RESET;
      nxt_st.sense_lo = irq_pkg::REG_RESET;
      nxt_st.mask = irq_pkg::REG_RESET;
      nxt_st.flags = irq_pkg::REG_RESET;
      nxt_st.wr_st = WR_ACCEPT;
      nxt_st.rd_st = RD_ACCEPT;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
      nxt_st.arready = 1'b1;
    end
  end

  // State register; low clock enable freezes it, reset always acts.
  always_ff @(posedge aclk) begin
    if (ce || !aresetn) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register.
  assign ext_irq_request = st_ff.ext_req;
  assign change_group0_request = st_ff.grp_req[irq_pkg::GRP0_BIT];
  assign change_group1_request = st_ff.grp_req[irq_pkg::GRP1_BIT];
  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence rise_seen4;
    ce && sense_all[9:8] == irq_pkg::SENSE_RISE && !st_ff.pin_p[4] &&
      st_ff.pin_s[4];
  endsequence

  sequence flag4_wr_one;
    ce && wr_take && wr_addr == irq_pkg::FLAGS_OFS && wr_byte[4] &&
      !edge_hit[4] && !ext_irq_ack[4];
  endsequence

  sequence low_held4;
    ce && gie && st_ff.mask[4] && lvl_v[4] && !st_ff.pin_s[4];
  endsequence

  ext_gate_a: assert property (ce && !gie |=> st_ff.ext_req == 8'h00)
    else $error("request raised without global enable");
  mask_gate_a: assert property ($past(ce) |->
    (st_ff.ext_req & ~$past(st_ff.mask)) == 8'h00)
    else $error("request raised on a masked pin");
  level_hold_a: assert property (low_held4 ##1 low_held4 |=>
    st_ff.ext_req[4] [*1])
    else $error("level request dropped while pin low");
  rise_flag_a: assert property (rise_seen4 |=> st_ff.flags[4])
    else $error("rising edge did not set its flag");
  edge_req_a: assert property (ce && gie && st_ff.mask[5] && !lvl_v[5] &&
    st_ff.flags[5] |=> ext_irq_request[5])
    else $error("set flag gave no request");
  level_clear_a: assert property ($past(ce) |->
    (st_ff.flags & $past(lvl_v)) == 8'h00)
    else $error("level-sensed flag not held clear");
  flag_w1c_a: assert property (flag4_wr_one |=> !st_ff.flags[4])
    else $error("writing one did not clear flag");
  ack_clear_a: assert property (ce && change_group_ack[1] && !grp_set[1]
    |=> !st_ff.pc_flag[1])
    else $error("handler entry did not clear group flag");
  group_flag_a: assert property (ce && st_ff.pc_msk_lo[0] &&
    st_ff.watch_s[0] != st_ff.watch_p[0] |=> st_ff.pc_flag[0])
    else $error("change did not set group flag");
  group_mask_a: assert property ($past(ce) && $rose(st_ff.pc_flag[0]) |->
    $past(|chg[7:0]))
    else $error("group flag set without enabled change");
  hi_mask_a: assert property (ce && st_ff.pc_msk_hi[4] &&
    st_ff.watch_s[12] != st_ff.watch_p[12] |=> st_ff.pc_flag[1])
    else $error("input twelve change missed");
  group_req_a: assert property ($past(ce) && change_group1_request |->
    $past(gie && st_ff.pc_flag[1] && st_ff.pc_en[1]))
    else $error("group request without flag and enables");
  resv_zero_a: assert property (ce && ar_fire &&
    araddr == irq_pkg::PC_CTRL_OFS |=> rvalid && rdata[31:2] == 30'h0)
    else $error("reserved control bits read nonzero");
  sleep_buf_a: assert property (ce && sleep_active && !st_ff.mask[0] |=>
    !st_ff.pin_s[0])
    else $error("masked lower pin seen during sleep");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped before taken");

endmodule // ext_pin_irq_ctrl

// >>> verilog/ext_sense_detect.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Compares two successive samples of one pin under its sense selection.
module ext_sense_detect (
  input wire logic [1:0] sense,
  input wire logic now_lvl,
  input wire logic prev_lvl,
  output logic hit
);

  // Level mode never reports an event; its flag is held clear instead.
  always_comb begin
    case (sense)
      irq_pkg::SENSE_ANY: hit = now_lvl ^ prev_lvl;
      irq_pkg::SENSE_FALL: hit = prev_lvl & ~now_lvl;
      irq_pkg::SENSE_RISE: hit = ~prev_lvl & now_lvl;
      default: hit = 1'b0;
    endcase
  end

endmodule // ext_sense_detect

// >>> verilog/irq_pkg.sv
package irq_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam int ADDR_W = 8;
  localparam logic [7:0] SENSE_HI_OFS = 8'h00;
  localparam logic [7:0] SENSE_LO_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] FLAGS_OFS = 8'h0C;
  localparam logic [7:0] PC_CTRL_OFS = 8'h10;
  localparam logic [7:0] PC_FLAGS_OFS = 8'h14;
  localparam logic [7:0] PC_MASK_LO_OFS = 8'h18;
  localparam logic [7:0] PC_MASK_HI_OFS = 8'h1C;

  // Reset value shared by every register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Sense selection codes, high bit then low bit.
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin counts and group split.
  localparam int EXT_PINS = 8;
  localparam int LOWER_PINS = 4;
  localparam int WATCH_PINS = 13;
  localparam int GRP0_W = 8;
  localparam int GRP1_W = 5;
  localparam int GRP0_BIT = 0;
  localparam int GRP1_BIT = 1;

endpackage
